// file: src/calc_pkg.sv
// Package: constants shared by the two input signal calculator
package calc_pkg;
	localparam int DW = 32;
	localparam int WW = 64;
	localparam int AW = 8;
	localparam int SW = 7;
	localparam int FW = 5;
	localparam int UW = 4;
	localparam int USE_N = 16;
	localparam int SRC_COUNT = 67;

	// Register byte offsets
	localparam logic [AW-1:0] OFS_USE = 8'h00;
	localparam logic [AW-1:0] OFS_ASRC = 8'h04;
	localparam logic [AW-1:0] OFS_BSRC = 8'h08;
	localparam logic [AW-1:0] OFS_FUNC = 8'h0C;
	localparam logic [AW-1:0] OFS_KVAL = 8'h10;
	localparam logic [AW-1:0] OFS_KMUL = 8'h14;
	localparam logic [AW-1:0] OFS_KDIV = 8'h18;
	localparam logic [AW-1:0] OFS_LOWER = 8'h1C;
	localparam logic [AW-1:0] OFS_UPPER = 8'h20;
	localparam logic [AW-1:0] OFS_RESULT = 8'h24;
	localparam logic [AW-1:0] OFS_KOUT = 8'h28;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Distributor uses
	localparam logic [UW-1:0] USE_NONE = 4'h0;
	localparam logic [UW-1:0] USE_FREF1 = 4'h1;
	localparam logic [UW-1:0] USE_FREF2 = 4'h2;
	localparam logic [UW-1:0] USE_FCORR = 4'h3;
	localparam logic [UW-1:0] USE_PREF = 4'h6;
	localparam logic [UW-1:0] USE_PACT = 4'h7;
	localparam logic [UW-1:0] USE_REQ = 4'hF;

	// Source codes with fixed meaning
	localparam logic [SW-1:0] SRC_NONE = 7'h00;
	localparam logic [SW-1:0] SRC_PCT0 = 7'h01;
	localparam logic [SW-1:0] SRC_PCT100 = 7'h02;

	// Function codes
	localparam logic [FW-1:0] FN_ADD = 5'h01;
	localparam logic [FW-1:0] FN_SUB = 5'h02;
	localparam logic [FW-1:0] FN_MUL = 5'h03;
	localparam logic [FW-1:0] FN_DIV = 5'h04;
	localparam logic [FW-1:0] FN_ROOT = 5'h05;
	localparam logic [FW-1:0] FN_NADD = 5'h06;
	localparam logic [FW-1:0] FN_NDIV = 5'h09;
	localparam logic [FW-1:0] FN_AADD = 5'h0A;
	localparam logic [FW-1:0] FN_ADIV = 5'h0D;
	localparam logic [FW-1:0] FN_MIN = 5'h0E;
	localparam logic [FW-1:0] FN_MAX = 5'h0F;
	localparam logic [FW-1:0] FN_AVG = 5'h10;
	localparam logic [FW-1:0] FN_ROUND = 5'h11;
	localparam logic [FW-1:0] FN_NEG_OFS = 5'h05;
	localparam logic [FW-1:0] FN_ABS_OFS = 5'h09;

	// Values in hundredths of a percent or hertz; MUL_MAX, DIV_MAX and ONE_CNT are plain factors
	localparam logic signed [WW-1:0] SCALE = 64'sh0000_0000_0000_0064;
	localparam logic signed [DW-1:0] PCT100 = 32'sh0000_2710;
	localparam logic signed [DW-1:0] VAL_MAX = 32'sh0000_7530;
	localparam logic signed [DW-1:0] VAL_MIN = -32'sh0000_7530;
	localparam logic signed [DW-1:0] MUL_MAX = 32'sh0000_7530;
	localparam logic signed [DW-1:0] DIV_MAX = 32'sh0000_03E8;
	localparam logic signed [DW-1:0] ONE_CNT = 32'sh0000_0001;
	localparam logic signed [WW-1:0] SAT = 64'sh0000_0000_7FFF_FFFF;

	// Reset values
	localparam logic [FW-1:0] RST_FUNC = FN_SUB;
	localparam logic signed [DW-1:0] RST_KVAL = 32'sh0000_0064;
	localparam logic signed [DW-1:0] RST_LOWER = 32'sh0000_0000;
	localparam logic signed [DW-1:0] RST_UPPER = 32'sh0000_3A98;
endpackage : calc_pkg

// file: src/calc_sqrt.sv
// Iterative integer square root, one result bit per cycle
`timescale 1ns/1ps
module calc_sqrt #(
	parameter int RW = 64
) (
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	input  wire logic            start,
	input  wire logic [RW-1:0]   radicand,
	output logic                 done,
	output logic [RW/2-1:0]      root
);
	import calc_pkg::*;
	localparam int HW = RW/2;
	localparam int CW = $clog2(HW+1);

	logic [RW-1:0] x_ff;
	logic [HW+1:0] rem_ff;
	logic [CW-1:0] cnt_ff;
	logic          busy_ff;
	logic [HW+1:0] rem_n;
	logic [HW+1:0] trial;

	always_comb begin
		rem_n = {rem_ff[HW-1:0], x_ff[RW-1 -: 2]};
		trial = {root, 2'h1};
	end

	// Restoring digit method: slow but tiny next to a 64-bit divider
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			x_ff <= '0;
			rem_ff <= '0;
			root <= '0;
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			x_ff <= radicand;
			rem_ff <= '0;
			root <= '0;
			cnt_ff <= CW'(HW);
			busy_ff <= 1'b1;
			done <= 1'b0;
		end else if (busy_ff) begin
			x_ff <= x_ff << 2;
			if (rem_n >= trial) begin
				rem_ff <= rem_n - trial;
				root <= {root[HW-2:0], 1'b1};
			end else begin
				rem_ff <= rem_n;
				root <= {root[HW-2:0], 1'b0};
			end
			cnt_ff <= cnt_ff - CW'(1);
			busy_ff <= (cnt_ff != CW'(1));
			done <= (cnt_ff == CW'(1));
		end else begin
			done <= 1'b0;
		end
	end

	// Latency fixed for the default width
	chk_root_latency: assert property (@(posedge clk_sys) disable iff (!resetn)
		start |-> ##33 done) else $error("root latency wrong");
endmodule : calc_sqrt

// file: src/calc_top.sv
// Two input signal calculator with AXI4-Lite settings
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module calc_top #(
	parameter int NUM_SRC = calc_pkg::SRC_COUNT
) (
	input  wire logic                        clk_sys,
	input  wire logic                        resetn,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [calc_pkg::AW-1:0]     s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [calc_pkg::DW-1:0]     s_axi_wdata,
	input  wire logic [calc_pkg::DW/8-1:0]   s_axi_wstrb,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [calc_pkg::AW-1:0]     s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [calc_pkg::DW-1:0]          s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	input  wire logic [NUM_SRC-1:0][calc_pkg::DW-1:0] src_vals,
	output logic signed [calc_pkg::DW-1:0]   dist_value,
	output logic [calc_pkg::USE_N-1:0]       dist_use
);
	import calc_pkg::*;

	typedef enum logic [1:0] {
		ST_LOAD = 2'h0,
		ST_CALC = 2'h1,
		ST_ROOT = 2'h3,
		ST_LIMIT = 2'h2
	} calc_st_t;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic [UW-1:0]          use_ff;
	logic [SW-1:0]          a_src_ff;
	logic [SW-1:0]          b_src_ff;
	logic [FW-1:0]          func_ff;
	logic signed [DW-1:0]   kval_ff;
	logic signed [DW-1:0]   kmul_ff;
	logic signed [DW-1:0]   kdiv_ff;
	logic signed [DW-1:0]   lower_ff;
	logic signed [DW-1:0]   upper_ff;
	logic signed [DW-1:0]   result_ff;
	logic [AW-1:0]          wr_addr_ff;
	logic [DW-1:0]          wr_data_ff;
	logic [DW/8-1:0]        wr_strb_ff;
	logic                   wr_go;
	logic                   wr_hit;
	logic [DW-1:0]          rd_data;
	logic                   rd_hit;
	calc_st_t               st_ff;
	logic signed [WW-1:0]   a_ff;
	logic signed [WW-1:0]   b_ff;
	logic signed [WW-1:0]   k_ff;
	logic signed [WW-1:0]   res_ff;
	logic signed [WW-1:0]   k_calc;
	logic signed [WW-1:0]   b_eff;
	logic signed [WW-1:0]   nxt_res;
	logic signed [WW-1:0]   diff;
	logic signed [WW-1:0]   half_k;
	logic signed [WW-1:0]   abs_k;
	logic signed [DW-1:0]   nxt_lim;
	logic [FW-1:0]          op;
	logic                   root_go_ff;
	logic                   root_done;
	logic [WW/2-1:0]        root_val;
	logic [WW-1:0]          radicand;

	// Fixed codes 0/1/2 are made here, others taken as delivered
	function automatic logic signed [WW-1:0] pick(input logic [SW-1:0] code);
		logic signed [DW-1:0] v;
		v = '0;
		if (code == SRC_PCT100)
			v = PCT100;
		else if (code > SRC_PCT0 && int'(code) < NUM_SRC)
			v = signed'(src_vals[code]);
		return {{(WW-DW){v[DW-1]}}, v};
	endfunction : pick

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old);
		logic [DW-1:0] m;
		m = old;
		for (int i = 0; i < DW/8; i++)
			if (wr_strb_ff[i])
				m[i*8 +: 8] = wr_data_ff[i*8 +: 8];
		return m;
	endfunction : merge

	function automatic logic signed [DW-1:0] clip(input logic signed [DW-1:0] v,
			input logic signed [DW-1:0] lo, input logic signed [DW-1:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clip

	// AXI4-Lite write: address and data taken in either order
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			wr_addr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			wr_addr_ff <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_wready <= 1'b1;
			wr_data_ff <= '0;
			wr_strb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wr_data_ff <= s_axi_wdata;
			wr_strb_ff <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_hit = (wr_addr_ff <= OFS_UPPER) && (wr_addr_ff[1:0] == 2'h0);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Illegal codes are dropped, numeric settings saturate into range
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			use_ff <= USE_NONE;
			a_src_ff <= SRC_NONE;
			b_src_ff <= SRC_NONE;
			func_ff <= RST_FUNC;
			kval_ff <= RST_KVAL;
			kmul_ff <= ONE_CNT;
			kdiv_ff <= ONE_CNT;
			lower_ff <= RST_LOWER;
			upper_ff <= RST_UPPER;
		end else if (wr_go) begin
			case (wr_addr_ff)
			OFS_USE: begin
				if (merge(DW'(use_ff)) inside {USE_NONE, USE_FREF1,
						USE_FREF2, USE_FCORR, USE_PREF, USE_PACT,
						USE_REQ})
					use_ff <= UW'(merge(DW'(use_ff)));
			end
			OFS_ASRC: begin
				if (merge(DW'(a_src_ff)) < DW'(NUM_SRC))
					a_src_ff <= SW'(merge(DW'(a_src_ff)));
			end
			OFS_BSRC: begin
				if (merge(DW'(b_src_ff)) < DW'(NUM_SRC))
					b_src_ff <= SW'(merge(DW'(b_src_ff)));
			end
			OFS_FUNC: begin
				if (merge(DW'(func_ff)) >= DW'(FN_ADD) &&
						merge(DW'(func_ff)) <= DW'(FN_ROUND))
					func_ff <= FW'(merge(DW'(func_ff)));
			end
			OFS_KVAL: kval_ff <= clip(merge(kval_ff), VAL_MIN, VAL_MAX);
			OFS_KMUL: kmul_ff <= clip(merge(kmul_ff), ONE_CNT, MUL_MAX);
			OFS_KDIV: kdiv_ff <= clip(merge(kdiv_ff), ONE_CNT, DIV_MAX);
			OFS_LOWER: lower_ff <= clip(merge(lower_ff), VAL_MIN, VAL_MAX);
			OFS_UPPER: upper_ff <= clip(merge(upper_ff), VAL_MIN, VAL_MAX);
			default: begin
			end
			endcase
		end
	end

	// AXI4-Lite read
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
		OFS_USE: rd_data = DW'(use_ff);
		OFS_ASRC: rd_data = DW'(a_src_ff);
		OFS_BSRC: rd_data = DW'(b_src_ff);
		OFS_FUNC: rd_data = DW'(func_ff);
		OFS_KVAL: rd_data = kval_ff;
		OFS_KMUL: rd_data = kmul_ff;
		OFS_KDIV: rd_data = kdiv_ff;
		OFS_LOWER: rd_data = lower_ff;
		OFS_UPPER: rd_data = upper_ff;
		OFS_RESULT: rd_data = result_ff;
		OFS_KOUT: rd_data = DW'(k_ff);
		default: begin
			rd_data = '0;
			rd_hit = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Divisor is never below one, so this divide is always defined
	assign k_calc = (WW'(kval_ff) * WW'(kmul_ff)) / WW'(kdiv_ff);

	always_comb begin
		b_eff = b_ff;
		op = func_ff;
		if (func_ff >= FN_NADD && func_ff <= FN_NDIV) begin
			b_eff = -b_ff;
			op = func_ff - FN_NEG_OFS;
		end else if (func_ff >= FN_AADD && func_ff <= FN_ADIV) begin
			b_eff = (b_ff < 0) ? -b_ff : b_ff;
			op = func_ff - FN_ABS_OFS;
		end
	end

	assign diff = a_ff - b_ff;
	assign radicand = ((diff < 0) ? -diff : diff) * SCALE;
	assign abs_k = (k_ff < 0) ? -k_ff : k_ff;
	assign half_k = abs_k >>> 1;

	always_comb begin
		nxt_res = res_ff;
		case (op)
		FN_ADD: nxt_res = a_ff + b_eff;
		FN_SUB: nxt_res = a_ff - b_eff;
		FN_MUL: nxt_res = (a_ff * b_eff) / SCALE;
		FN_DIV: begin
			if (b_eff == 0)
				nxt_res = (a_ff < 0) ? -SAT : SAT;
			else
				nxt_res = (a_ff * SCALE) / b_eff;
		end
		FN_MIN: nxt_res = (a_ff < b_ff) ? a_ff : b_ff;
		FN_MAX: nxt_res = (a_ff > b_ff) ? a_ff : b_ff;
		FN_AVG: nxt_res = (a_ff + b_ff) >>> 1;
		FN_ROUND: begin
			if (abs_k == 0)
				nxt_res = a_ff;
			else if (a_ff < 0)
				nxt_res = ((a_ff - half_k) / abs_k) * abs_k;
			else
				nxt_res = ((a_ff + half_k) / abs_k) * abs_k;
		end
		default: nxt_res = res_ff;
		endcase
	end

	// Sequence state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_ff <= ST_LOAD;
		end else begin
			case (st_ff)
			ST_LOAD: st_ff <= ST_CALC;
			ST_CALC: st_ff <= (func_ff == FN_ROOT) ? ST_ROOT : ST_LIMIT;
			ST_ROOT: begin
				if (root_done)
					st_ff <= ST_LIMIT;
			end
			ST_LIMIT: st_ff <= ST_LOAD;
			default: st_ff <= ST_LOAD;
			endcase
		end
	end

	// Operands held steady for the whole calculation
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			a_ff <= '0;
			b_ff <= '0;
			k_ff <= '0;
		end else if (st_ff == ST_LOAD) begin
			a_ff <= pick(a_src_ff);
			b_ff <= (b_src_ff == SRC_NONE) ? k_calc : pick(b_src_ff);
			k_ff <= k_calc;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			res_ff <= '0;
			root_go_ff <= 1'b0;
		end else begin
			root_go_ff <= (st_ff == ST_CALC) && (func_ff == FN_ROOT);
			if (st_ff == ST_CALC && func_ff != FN_ROOT)
				res_ff <= nxt_res;
			else if (st_ff == ST_ROOT && root_done)
				// Signed product, so a negative k keeps its sign
				res_ff <= (signed'({{(WW/2){1'b0}}, root_val}) * k_ff)
					/ SCALE;
		end
	end

	calc_sqrt #(
		.RW(WW)
	) u_sqrt (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.start    (root_go_ff),
		.radicand (radicand),
		.done     (root_done),
		.root     (root_val)
	);

	// If the limits are crossed, results above upper_ff give upper_ff, all others lower_ff
	always_comb begin
		if (res_ff > WW'(upper_ff))
			nxt_lim = upper_ff;
		else if (res_ff < WW'(lower_ff))
			nxt_lim = lower_ff;
		else
			nxt_lim = DW'(res_ff);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			result_ff <= '0;
			dist_value <= '0;
			dist_use <= '0;
		end else if (st_ff == ST_LIMIT) begin
			result_ff <= nxt_lim;
			if (use_ff == USE_NONE) begin
				dist_value <= '0;
				dist_use <= '0;
			end else begin
				dist_value <= nxt_lim;
				dist_use <= USE_N'(1) << use_ff;
			end
		end
	end

	chk_use_onehot: assert property ($onehot0(dist_use))
		else $error("more than one use driven");
	chk_unused_silent: assert property (dist_use == '0 |-> dist_value == '0)
		else $error("value driven with no use");
	chk_pct_source: assert property (st_ff == ST_LOAD &&
		a_src_ff == SRC_PCT100 |=> a_ff == WW'(PCT100))
		else $error("fixed source wrong");
	chk_const_subst: assert property (st_ff == ST_LOAD &&
		b_src_ff == SRC_NONE |=> b_ff == $past(k_calc))
		else $error("constant not used for B");
	chk_add_result: assert property (st_ff == ST_CALC && func_ff == FN_ADD
		|=> res_ff == $past(a_ff) + $past(b_ff))
		else $error("add result wrong");
	chk_neg_sub: assert property (st_ff == ST_CALC && func_ff == 5'h07
		|=> res_ff == $past(a_ff) + $past(b_ff))
		else $error("negated B subtract wrong");
	chk_div_zero: assert property (st_ff == ST_CALC && op == FN_DIV &&
		b_eff == 0 |=> res_ff == SAT || res_ff == -SAT)
		else $error("divide by zero not saturated");
	chk_avg_result: assert property (st_ff == ST_CALC && func_ff == FN_AVG
		|=> res_ff == ($past(a_ff) + $past(b_ff)) >>> 1)
		else $error("average wrong");
	chk_limit_bounds: assert property (st_ff == ST_LIMIT &&
		use_ff != USE_NONE && lower_ff <= upper_ff
		|=> dist_value >= $past(lower_ff) && dist_value <= $past(upper_ff))
		else $error("result outside limits");
	chk_root_ends: assert property (st_ff == ST_CALC && func_ff == FN_ROOT
		|=> st_ff == ST_ROOT ##[1:40] st_ff == ST_LIMIT)
		else $error("root step hangs");

	cov_write_done: cover property (s_axi_bvalid && s_axi_bready);
	cov_root_path: cover property (st_ff == ST_ROOT && root_done);
	cov_clamped: cover property (st_ff == ST_LIMIT && use_ff != USE_NONE &&
		res_ff > WW'(upper_ff));
endmodule : calc_top

// file: tb/calc_src_model.sv
// Signal sources that feed the calculator operand selectors
`timescale 1ns/1ps
module calc_src_model #(
	parameter int NUM_SRC = calc_pkg::SRC_COUNT
) (
	input  wire logic                                 clk_sys,
	input  wire logic                                 set_en,
	input  wire logic [7:0]                           set_idx,
	input  wire logic [calc_pkg::DW-1:0]              set_val,
	output logic [NUM_SRC-1:0][calc_pkg::DW-1:0]      src_vals
);
	import calc_pkg::*;
	logic [NUM_SRC-1:0][DW-1:0] sig_ff;

	// Distinct start values so a wrong selector shows at once
	initial begin
		for (int i = 0; i < NUM_SRC; i++) begin
			sig_ff[i] = 32'h0000_0101 * i;
		end
	end

	// Sources deliver values already scaled, hundredths of % or Hz
	always @(posedge clk_sys) begin
		if (set_en && set_idx < NUM_SRC) begin
			sig_ff[set_idx] <= set_val;
		end
	end

	// Fixed 0% and 100% entries of the coded list
	always_comb begin
		src_vals = sig_ff;
		src_vals[0] = '0;
		src_vals[1] = '0;
		src_vals[2] = PCT100;
	end
endmodule : calc_src_model

// file: tb/calc_top_tb.sv
// Bench for the two input signal calculator
`timescale 1ns/1ps
module calc_top_tb;
	import calc_pkg::*;
	logic                          clk_sys;
	logic                          resetn;
	logic                          awv, awready, wv, wready, bvalid, bready;
	logic                          arv, arready, rvalid, rready;
	logic [AW-1:0]                 awaddr, araddr;
	logic [DW-1:0]                 wdata, rdata, ev, eu;
	logic [1:0]                    bresp, rresp;
	logic [SRC_COUNT-1:0][DW-1:0]  srcs;
	logic signed [DW-1:0]          dist_value;
	logic [USE_N-1:0]              dist_use;
	logic                          set_en;
	logic [7:0]                    set_idx;
	logic [DW-1:0]                 set_val;
	int                            n_mismatch;
	int                            num_checks;
	// A = 50.00, B = -20.00, limits -200.00 .. 200.00, k = 1.00
	logic [DW-1:0] fn_exp [17] = '{32'h0BB8, 32'h1B58, 32'hFFFF_B1E0,
		32'hFFFF_FF06, 32'h0344, 32'h1B58, 32'h0BB8, 32'h4E20, 32'h00FA,
		32'h1B58, 32'h0BB8, 32'h4E20, 32'h00FA, 32'hFFFF_F830, 32'h1388,
		32'h05DC, 32'h1388};
	logic [DW-1:0] dflt [9] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h64, 32'h1,
		32'h1, 32'h0, 32'h3A98};
	logic [3:0] uses [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hF};

	calc_top u_calc_top (
		.clk_sys(clk_sys), .resetn(resetn),
		.s_axi_awvalid(awv), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.src_vals(srcs), .dist_value(dist_value), .dist_use(dist_use)
	);

	calc_src_model u_calc_src_model (
		.clk_sys(clk_sys), .set_en(set_en), .set_idx(set_idx),
		.set_val(set_val), .src_vals(srcs)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Address and data offered together, each released once taken
	task automatic put(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] rexp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awv <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wv <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				chk({30'h0, bresp}, {30'h0, rexp});
				bready <= 1'b0;
				break;
			end
		end
	endtask : put

	task automatic look(input logic [7:0] a, input logic [31:0] exp,
			input logic [1:0] rexp);
		logic ar_done;
		ar_done = 1'b0;
		@(posedge clk_sys);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (!ar_done && arready === 1'b1) begin
				ar_done = 1'b1;
				arv <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				chk(rdata, exp);
				chk({30'h0, rresp}, {30'h0, rexp});
				rready <= 1'b0;
				break;
			end
		end
	endtask : look

	task automatic set_src(input logic [7:0] idx, input logic [31:0] v);
		@(posedge clk_sys);
		set_en <= 1'b1;
		set_idx <= idx;
		set_val <= v;
		@(posedge clk_sys);
		set_en <= 1'b0;
	endtask : set_src

	// Settings land within two loops; the root loop is the longest
	task automatic out_chk(input logic [31:0] v, input logic [31:0] u);
		repeat (100) @(posedge clk_sys);
		chk(dist_value, v);
		chk({16'h0, dist_use}, u);
	endtask : out_chk

	initial begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		n_mismatch = 0;
		num_checks = 0;
		resetn = 1'b0;
		{awv, wv, bready, arv, rready, set_en} = '0;
		{awaddr, araddr, wdata, set_idx, set_val} = '0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		chk(dist_value, 32'h0);
		chk({16'h0, dist_use}, 32'h0);
		for (int i = 0; i < 9; i++) begin
			look(8'(4 * i), dflt[i], RESP_OKAY);
		end
		put(OFS_RESULT, 32'h1, RESP_SLVERR);
		look(8'h30, 32'h0, RESP_SLVERR);
		// Default limits and subtract with the constant as B
		set_src(8'h3A, 32'h4E20);
		put(OFS_ASRC, 32'h3A, RESP_OKAY);
		put(OFS_USE, 32'h1, RESP_OKAY);
		out_chk(32'h3A98, 32'h2);
		set_src(8'h3A, 32'hFFFF_EC78);
		out_chk(32'h0, 32'h2);
		put(OFS_LOWER, 32'hFFFF_B1E0, RESP_OKAY);
		put(OFS_UPPER, 32'h4E20, RESP_OKAY);
		set_src(8'h3A, 32'h1388);
		set_src(8'h3E, 32'hFFFF_F830);
		put(OFS_BSRC, 32'h3E, RESP_OKAY);
		for (int f = 1; f <= 17; f++) begin
			put(OFS_FUNC, 32'(f), RESP_OKAY);
			out_chk(fn_exp[f - 1], 32'h2);
		end
		put(OFS_FUNC, 32'h1, RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			put(OFS_USE, {28'h0, uses[i]}, RESP_OKAY);
			eu = (uses[i] == 4'h0) ? 32'h0 : (32'h1 << uses[i]);
			ev = (uses[i] == 4'h0) ? 32'h0 : 32'h0BB8;
			out_chk(ev, eu);
			look(OFS_RESULT, 32'h0BB8, RESP_OKAY);
		end
		// Unlisted use code is ignored
		put(OFS_USE, 32'h4, RESP_OKAY);
		out_chk(32'h0BB8, 32'h8000);
		put(OFS_USE, 32'h1, RESP_OKAY);
		set_src(8'h3E, 32'h0);
		put(OFS_FUNC, 32'h4, RESP_OKAY);
		out_chk(32'h4E20, 32'h2);
		// Constant 300.00 x 3 / 7 replaces B
		put(OFS_BSRC, 32'h0, RESP_OKAY);
		put(OFS_KVAL, 32'h7530, RESP_OKAY);
		put(OFS_KMUL, 32'h3, RESP_OKAY);
		put(OFS_KDIV, 32'h7, RESP_OKAY);
		// Read-back of k follows the settings only at the next load
		repeat (8) @(posedge clk_sys);
		look(OFS_KOUT, 32'h3239, RESP_OKAY);
		put(OFS_FUNC, 32'h1, RESP_OKAY);
		out_chk(32'h45C1, 32'h2);
		put(OFS_KVAL, 32'h9C40, RESP_OKAY);
		look(OFS_KVAL, 32'h7530, RESP_OKAY);
		put(OFS_KMUL, 32'h0, RESP_OKAY);
		look(OFS_KMUL, 32'h1, RESP_OKAY);
		put(OFS_KDIV, 32'h1388, RESP_OKAY);
		look(OFS_KDIV, 32'h3E8, RESP_OKAY);
		// Round 13.71 to a multiple of 0.20
		put(OFS_KVAL, 32'h14, RESP_OKAY);
		put(OFS_KDIV, 32'h1, RESP_OKAY);
		set_src(8'h3A, 32'h055B);
		put(OFS_FUNC, 32'h11, RESP_OKAY);
		out_chk(32'h0564, 32'h2);
		put(OFS_ASRC, 32'h2, RESP_OKAY);
		put(OFS_BSRC, 32'h1, RESP_OKAY);
		put(OFS_FUNC, 32'h1, RESP_OKAY);
		out_chk(32'h2710, 32'h2);
		// Root of 100.00 times k = -1.00
		put(OFS_KVAL, 32'hFFFF_FF9C, RESP_OKAY);
		put(OFS_FUNC, 32'h5, RESP_OKAY);
		out_chk(32'hFFFF_FC18, 32'h2);
		give_verdict();
	end
endmodule : calc_top_tb
